// [inc/sfqf_if.sv]
// serial flash link: select, clock, four data lanes with enables
// assumes device and host modules; enables active low (0 drives)
`timescale 1ns/1ps
interface sfqf_if;
   logic cs_n;
   logic sclk;
   logic [3:0] host_do;
   logic [3:0] host_oe_n;
   logic [3:0] dev_do;
   logic [3:0] dev_oe_n;
   logic [3:0] lane;
   genvar g;
   for (g = 0; g < 4; g++) begin : g_lane
      assign lane[g] = !host_oe_n[g] ? host_do[g] : (!dev_oe_n[g] ? dev_do[g] : 1'b1);
   end
   modport dev (input cs_n, input sclk, input lane, output dev_do, output dev_oe_n);
   modport host (output cs_n, output sclk, input lane, output host_do, output host_oe_n);
endinterface : sfqf_if

// [inc/sfqf_pkg.sv]
// constants shared by the serial flash front end and its host end
// assumes both ends run on one system clock and meet in sfqf_if
// Function
// - select high floats all data outputs
// - no instruction before first select fall
// - single mode input sampled on rising clock
// - single mode output changes on falling clock
// - dual/quad lines bidirectional, same edges
// - quad only with quad enable set
// - write-protect pin blocks status writes; here only with status bit 5 set and quad enable clear
// - protect fields cover sector to array; the status byte here holds no protect fields
// - clock modes 0 and 3 supported
// - 3Bh and BBh use two lines
// - 6Bh EBh E7h E3h use four lines
// - 38h enters, FFh leaves four-wire mode
// - four-wire opcode two clocks, serial eight
// - reset and 99h start in serial mode
// - four-wire entry needs quad enable bit
// - pause only with quad enable clear
// - pause begins with clock low
// - pause ends with clock low, resumes
// - paused: output floats, inputs ignored
// - host keeps select low during pause
// - shared pin pause or reset, dedicated reset
// - config bit selects reset, 1us resets
// - 66h then 99h, 30us busy
package sfqf_pkg;
   localparam logic [7:0] SFQF_OP_DUAL_OUT = 8'h3B;
   localparam logic [7:0] SFQF_OP_DUAL_IO = 8'hBB;
   localparam logic [7:0] SFQF_OP_QUAD_OUT = 8'h6B;
   localparam logic [7:0] SFQF_OP_QUAD_IO = 8'hEB;
   localparam logic [7:0] SFQF_OP_WORD_QIO = 8'hE7;
   localparam logic [7:0] SFQF_OP_OCT_QIO = 8'hE3;
   localparam logic [7:0] SFQF_OP_ENTER_4W = 8'h38;
   localparam logic [7:0] SFQF_OP_EXIT_4W = 8'hFF;
   localparam logic [7:0] SFQF_OP_EN_RST = 8'h66;
   localparam logic [7:0] SFQF_OP_RST = 8'h99;
   localparam logic [7:0] SFQF_OP_WR_STATUS = 8'h01;
   localparam logic [7:0] SFQF_OP_RD_STATUS = 8'h05;
   localparam int SFQF_CLK_MHZ = 100;
   localparam int SFQF_TRST_US = 30;
   localparam int SFQF_TRST_CYC = SFQF_TRST_US * SFQF_CLK_MHZ;
   localparam int SFQF_TRESET_US = 1;
   localparam int SFQF_TRESET_CYC = SFQF_TRESET_US * SFQF_CLK_MHZ;
   localparam int SFQF_CNT_W = 16;
   localparam logic [2:0] SFQF_BITS_LAST = 3'h7;
   localparam logic [7:0] SFQF_STATUS_RESET = 8'h00;
   localparam int SFQF_LANES = 4;
   // status byte field positions
   localparam int SFQF_ST_QE = 7;
   localparam int SFQF_ST_HOLD_RST = 6;
   localparam int SFQF_ST_SRP = 5;
   typedef enum logic [1:0] {
      SFQF_W1 = 2'h0,
      SFQF_W2 = 2'h1,
      SFQF_W4 = 2'h2
   } sfqf_width_t;
   typedef enum logic [3:0] {
      SFQF_ST_IDLE = 4'h1,
      SFQF_ST_OPC = 4'h2,
      SFQF_ST_DATA = 4'h4,
      SFQF_ST_BUSY = 4'h8
   } sfqf_state_t;
   function automatic logic [1:0] sfqf_width(input logic [7:0] op);
      if (op == SFQF_OP_DUAL_OUT || op == SFQF_OP_DUAL_IO) begin
         sfqf_width = SFQF_W2;
      end else if (op == SFQF_OP_QUAD_OUT || op == SFQF_OP_QUAD_IO ||
                   op == SFQF_OP_WORD_QIO || op == SFQF_OP_OCT_QIO) begin
         sfqf_width = SFQF_W4;
      end else begin
         sfqf_width = SFQF_W1;
      end
   endfunction : sfqf_width
endpackage : sfqf_pkg

// [rtl/sfqf_device.sv]
// device end: opcode decode, lane roles, pause, status, resets
// assumes link pins asynchronous to clk_i; all pins synchronised first
`timescale 1ns/1ps
module sfqf_device (
   input wire logic clk_i,
   input wire logic reset_i,
   sfqf_if.dev link,
   input wire logic reset_pin_n_i,
   input wire logic [7:0] rd_data_i,
   output logic [7:0] status_o,
   output logic [7:0] opcode_o,
   output logic opcode_valid_o,
   output logic [7:0] wr_data_o,
   output logic wr_valid_o,
   output logic four_wire_o,
   output logic busy_o,
   output logic paused_o
);
   localparam int SFQF_CNT_W = sfqf_pkg::SFQF_CNT_W;
   logic [2:0] cs_s, ck_s;
   logic [3:0] ln_s0, ln_s1;
   logic [1:0] rp_s;
   logic cs_prev_q, ck_prev_q, hold_prev_q;
   logic armed_q, paused_q, hold_pend_q, en_rst_q;
   logic [7:0] sh_q;
   logic [2:0] cnt_q;
   logic [1:0] width_q;
   logic [7:0] tx_q;
   logic [3:0] do_q, oe_n_q;
   logic [7:0] status_q;
   logic [SFQF_CNT_W-1:0] busy_cnt_q, rpin_cnt_q;
   sfqf_pkg::sfqf_state_t st_q;
   logic cs_n, ck, rise, fall, cs_fall, qe, hold_n, hold_en, wp_n, sw_rst, hw_rst;
   logic [7:0] shift_in;
   logic [2:0] step;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cs_s <= 3'h7;
         ck_s <= 3'h0;
         ln_s0 <= 4'hF;
         ln_s1 <= 4'hF;
         rp_s <= 2'h3;
      end else begin
         cs_s <= {cs_s[1:0], link.cs_n};
         ck_s <= {ck_s[1:0], link.sclk};
         ln_s0 <= link.lane;
         ln_s1 <= ln_s0;
         rp_s <= {rp_s[0], reset_pin_n_i};
      end
   end
   assign cs_n = cs_s[2];
   assign ck = ck_s[2];
   assign rise = ck && !ck_prev_q;
   assign fall = !ck && ck_prev_q;
   assign cs_fall = !cs_n && cs_prev_q;
   assign qe = status_q[sfqf_pkg::SFQF_ST_QE];
   // shared lane 3: pause or reset only while quad disabled
   assign hold_en = !qe && !status_q[sfqf_pkg::SFQF_ST_HOLD_RST];
   assign hold_n = ln_s1[3];
   assign wp_n = qe ? 1'b1 : ln_s1[2];
   assign step = (width_q == sfqf_pkg::SFQF_W4) ? 3'h4 :
                 ((width_q == sfqf_pkg::SFQF_W2) ? 3'h2 : 3'h1);
   always_comb begin
      shift_in = {sh_q[6:0], ln_s1[0]};
      if (width_q == sfqf_pkg::SFQF_W2) begin
         shift_in = {sh_q[5:0], ln_s1[1:0]};
      end else if (width_q == sfqf_pkg::SFQF_W4) begin
         shift_in = {sh_q[3:0], ln_s1};
      end
   end
   // dedicated pin always resets; shared lane only when configured
   assign hw_rst = rpin_cnt_q >= SFQF_CNT_W'(sfqf_pkg::SFQF_TRESET_CYC);

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rpin_cnt_q <= '0;
      end else if (!rp_s[1] || (!qe && status_q[sfqf_pkg::SFQF_ST_HOLD_RST] &&
                                !ln_s1[3] && !cs_n)) begin
         if (!hw_rst) rpin_cnt_q <= rpin_cnt_q + 1'b1;
      end else begin
         rpin_cnt_q <= '0;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cs_prev_q <= 1'b1;
         ck_prev_q <= 1'b0;
         hold_prev_q <= 1'b1;
      end else begin
         cs_prev_q <= cs_n;
         ck_prev_q <= ck;
         hold_prev_q <= hold_n;
      end
   end

   // pause entry/exit synchronised to clock low
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         paused_q <= 1'b0;
         hold_pend_q <= 1'b0;
      end else if (cs_n || !hold_en || hw_rst) begin
         paused_q <= 1'b0;
         hold_pend_q <= 1'b0;
      end else if (hold_n == paused_q) begin
         if (!ck && (hold_n != hold_prev_q || hold_pend_q)) begin
            paused_q <= !hold_n;
            hold_pend_q <= 1'b0;
         end else if (ck) begin
            hold_pend_q <= 1'b1;
         end
      end else begin
         hold_pend_q <= 1'b0;
      end
   end

   assign sw_rst = (st_q == sfqf_pkg::SFQF_ST_OPC) && rise && !paused_q &&
                   cnt_q == (3'h0 - step) && en_rst_q && shift_in == sfqf_pkg::SFQF_OP_RST;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_q <= sfqf_pkg::SFQF_ST_IDLE;
         armed_q <= 1'b0;
         sh_q <= 8'h00;
         cnt_q <= 3'h0;
         width_q <= sfqf_pkg::SFQF_W1;
         four_wire_o <= 1'b0;
         en_rst_q <= 1'b0;
         status_q <= sfqf_pkg::SFQF_STATUS_RESET;
         opcode_o <= 8'h00;
         opcode_valid_o <= 1'b0;
         wr_data_o <= 8'h00;
         wr_valid_o <= 1'b0;
         busy_cnt_q <= '0;
      end else begin
         opcode_valid_o <= 1'b0;
         wr_valid_o <= 1'b0;
         if (hw_rst) begin
            st_q <= sfqf_pkg::SFQF_ST_IDLE;
            armed_q <= 1'b0;
            four_wire_o <= 1'b0;
            en_rst_q <= 1'b0;
            status_q <= sfqf_pkg::SFQF_STATUS_RESET;
         end else if (st_q == sfqf_pkg::SFQF_ST_BUSY) begin
            if (busy_cnt_q == '0) st_q <= sfqf_pkg::SFQF_ST_IDLE;
            else busy_cnt_q <= busy_cnt_q - 1'b1;
            four_wire_o <= 1'b0;
         end else if (cs_n) begin
            st_q <= sfqf_pkg::SFQF_ST_IDLE;
            armed_q <= 1'b1;
         end else if (cs_fall && armed_q) begin
            st_q <= sfqf_pkg::SFQF_ST_OPC;
            cnt_q <= 3'h0;
            width_q <= four_wire_o ? sfqf_pkg::SFQF_W4 : sfqf_pkg::SFQF_W1;
         end else if (rise && !paused_q && st_q != sfqf_pkg::SFQF_ST_IDLE) begin
            sh_q <= shift_in;
            cnt_q <= cnt_q + step;
            if (cnt_q == (3'h0 - step)) begin
               if (st_q == sfqf_pkg::SFQF_ST_OPC) begin
                  opcode_o <= shift_in;
                  opcode_valid_o <= 1'b1;
                  st_q <= sfqf_pkg::SFQF_ST_DATA;
                  en_rst_q <= shift_in == sfqf_pkg::SFQF_OP_EN_RST;
                  if (sw_rst) begin
                     st_q <= sfqf_pkg::SFQF_ST_BUSY;
                     busy_cnt_q <= SFQF_CNT_W'(sfqf_pkg::SFQF_TRST_CYC);
                  end
                  if (shift_in == sfqf_pkg::SFQF_OP_ENTER_4W && qe) begin
                     four_wire_o <= 1'b1;
                  end
                  if (shift_in == sfqf_pkg::SFQF_OP_EXIT_4W) four_wire_o <= 1'b0;
                  if (!four_wire_o) begin
                     if (sfqf_pkg::sfqf_width(shift_in) == sfqf_pkg::SFQF_W4) begin
                        // quad codes fall back to single lane without enable
                        width_q <= qe ? sfqf_pkg::SFQF_W4 : sfqf_pkg::SFQF_W1;
                     end else begin
                        width_q <= sfqf_pkg::sfqf_width(shift_in);
                     end
                  end
               end else begin
                  wr_data_o <= shift_in;
                  wr_valid_o <= 1'b1;
                  // lock bit plus low pin blocks the status write
                  if (opcode_o == sfqf_pkg::SFQF_OP_WR_STATUS &&
                      !(status_q[sfqf_pkg::SFQF_ST_SRP] && !wp_n)) begin
                     status_q <= shift_in;
                  end
               end
            end
         end
      end
   end

   // read data shifted out on falling clock, msb first
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         tx_q <= 8'h00;
         do_q <= 4'h0;
         oe_n_q <= 4'hF;
      end else if (cs_n || paused_q || st_q != sfqf_pkg::SFQF_ST_DATA) begin
         oe_n_q <= 4'hF;
         // byte kept through a pause; last load happens as the opcode lands
         if (st_q != sfqf_pkg::SFQF_ST_DATA) begin
            tx_q <= (((st_q == sfqf_pkg::SFQF_ST_OPC) ? shift_in : opcode_o) ==
                     sfqf_pkg::SFQF_OP_RD_STATUS) ? status_q : rd_data_i;
         end
      end else if (fall && opcode_o != sfqf_pkg::SFQF_OP_WR_STATUS) begin
         if (width_q == sfqf_pkg::SFQF_W4) begin
            do_q <= tx_q[7:4];
            oe_n_q <= 4'h0;
            tx_q <= {tx_q[3:0], 4'h0};
         end else if (width_q == sfqf_pkg::SFQF_W2) begin
            do_q <= {2'h0, tx_q[7:6]};
            oe_n_q <= 4'hC;
            tx_q <= {tx_q[5:0], 2'h0};
         end else begin
            do_q <= {2'h0, tx_q[7], 1'b0};
            oe_n_q <= 4'hD;
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end
   assign link.dev_do = do_q;
   assign link.dev_oe_n = oe_n_q;
   assign status_o = status_q;
   assign busy_o = st_q == sfqf_pkg::SFQF_ST_BUSY;
   assign paused_o = paused_q;
endmodule : sfqf_device

// [rtl/sfqf_host.sv]
// host end: register port drives one byte transfers on the link
// assumes software sequences select, width and direction via registers
`timescale 1ns/1ps
module sfqf_host (
   input wire logic clk_i,
   input wire logic reset_i,
   sfqf_if.host link,
   input wire logic [1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o
);
   // reg 0 control: [0] select, [2:1] width, [3] read dir, [4] pause request; reg 1 data
   localparam logic [1:0] SFQH_REG_CTRL = 2'h0;
   localparam logic [1:0] SFQH_REG_DATA = 2'h1;
   localparam logic [1:0] SFQH_REG_STAT = 2'h2;
   // long half period: device output latency plus our synchroniser must fit
   localparam logic [2:0] SFQH_HALF = 3'h7;
   logic sel_q, dir_q, busy_q, sclk_q, hold_q;
   logic [1:0] width_q;
   logic [7:0] tx_q, rx_q;
   logic [2:0] div_q, cnt_q;
   logic [3:0] ln_s0, ln_s1;
   logic [2:0] step;
   assign step = (width_q == sfqf_pkg::SFQF_W4) ? 3'h4 :
                 ((width_q == sfqf_pkg::SFQF_W2) ? 3'h2 : 3'h1);
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ln_s0 <= 4'hF;
         ln_s1 <= 4'hF;
      end else begin
         ln_s0 <= link.lane;
         ln_s1 <= ln_s0;
      end
   end
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sel_q <= 1'b0;
         dir_q <= 1'b0;
         hold_q <= 1'b0;
         width_q <= sfqf_pkg::SFQF_W1;
         busy_q <= 1'b0;
         sclk_q <= 1'b0;
         tx_q <= 8'h00;
         rx_q <= 8'h00;
         div_q <= 3'h0;
         cnt_q <= 3'h0;
      end else begin
         if (wr_i && !busy_q) begin
            if (addr_i == SFQH_REG_CTRL) begin
               sel_q <= wdata_i[0];
               width_q <= wdata_i[2:1];
               dir_q <= wdata_i[3];
               hold_q <= wdata_i[4];
            end else if (addr_i == SFQH_REG_DATA && sel_q) begin
               tx_q <= wdata_i;
               busy_q <= 1'b1;
               cnt_q <= 3'h0;
               div_q <= 3'h0;
            end
         end else if (busy_q) begin
            div_q <= div_q + 3'h1;
            if (div_q == SFQH_HALF) begin
               div_q <= 3'h0;
               sclk_q <= !sclk_q;
               if (!sclk_q) begin
                  // device samples on this rise; shift in on read
                  if (width_q == sfqf_pkg::SFQF_W4) rx_q <= {rx_q[3:0], ln_s1};
                  else if (width_q == sfqf_pkg::SFQF_W2) rx_q <= {rx_q[5:0], ln_s1[1:0]};
                  else rx_q <= {rx_q[6:0], ln_s1[1]};
               end else begin
                  cnt_q <= cnt_q + step;
                  if (width_q == sfqf_pkg::SFQF_W4) tx_q <= {tx_q[3:0], 4'h0};
                  else if (width_q == sfqf_pkg::SFQF_W2) tx_q <= {tx_q[5:0], 2'h0};
                  else tx_q <= {tx_q[6:0], 1'b0};
                  if (cnt_q == (3'h0 - step)) busy_q <= 1'b0;
               end
            end
         end
      end
   end
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         if (addr_i == SFQH_REG_CTRL) rdata_o <= {3'h0, hold_q, dir_q, width_q, sel_q};
         else if (addr_i == SFQH_REG_DATA) rdata_o <= rx_q;
         else if (addr_i == SFQH_REG_STAT) rdata_o <= {7'h00, busy_q};
         else rdata_o <= 8'h00;
      end
   end
   assign link.cs_n = !sel_q;
   assign link.sclk = sclk_q;
   always_comb begin
      link.host_do = {tx_q[7:4]};
      link.host_oe_n = 4'hF;
      if (!dir_q && sel_q) begin
         if (width_q == sfqf_pkg::SFQF_W4) begin
            link.host_oe_n = 4'h0;
         end else if (width_q == sfqf_pkg::SFQF_W2) begin
            link.host_do = {2'h0, tx_q[7:6]};
            link.host_oe_n = 4'hC;
         end else begin
            link.host_do = {!hold_q, 2'h3, tx_q[7]};
            link.host_oe_n = 4'h2; // lane 2 high: no protect; lane 3 low pauses
         end
      end
   end
endmodule : sfqf_host

// [tb/sfqf_front_end_test.sv]
// bench top: device and host ends joined by sfqf_if, driven through host registers
// assumes host ctrl bit0 select, bits 2:1 width; reg2 bit0 busy
`timescale 1ns/1ps
module sfqf_front_end_test;
   logic clk_i;
   logic reset_i;
   logic reset_pin_n;
   logic [7:0] rd_data, status, opcode, wr_data, wdata, rdata;
   logic opcode_valid, wr_valid, four_wire, busy, paused, wr, rd;
   logic [1:0] addr;
   logic [7:0] mon1, mon4, rv;
   logic [7:0] codes [6] = '{8'h3B, 8'hBB, 8'h6B, 8'hEB, 8'hE7, 8'hE3};
   int errors, checked, cycles, op_cnt, n;
   sfqf_if link ();
   sfqf_device u_sfqf_device (.clk_i(clk_i), .reset_i(reset_i), .link(link),
      .reset_pin_n_i(reset_pin_n), .rd_data_i(rd_data), .status_o(status), .opcode_o(opcode),
      .opcode_valid_o(opcode_valid), .wr_data_o(wr_data), .wr_valid_o(wr_valid),
      .four_wire_o(four_wire), .busy_o(busy), .paused_o(paused));
   sfqf_host u_sfqf_host (.clk_i(clk_i), .reset_i(reset_i), .link(link), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
   sfqf_link_chk u_sfqf_link_chk (.clk_i(clk_i), .reset_i(reset_i), .cs_n(link.cs_n),
      .sclk(link.sclk), .host_do(link.host_do), .host_oe_n(link.host_oe_n),
      .dev_do(link.dev_do), .dev_oe_n(link.dev_oe_n));
   // wire-side view of what was shifted, independent of either end
   always @(posedge link.sclk) begin
      if (!link.cs_n) begin
         mon1 <= {mon1[6:0], link.lane[0]};
         mon4 <= {mon4[3:0], link.lane};
      end
   end
   task check(input logic [7:0] seen, input logic [7:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task print_verdict();
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (opcode_valid === 1'b1) op_cnt <= op_cnt + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         print_verdict();
      end
   end
   task reg_wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask : reg_wr
   task reg_rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : reg_rd
   task send_byte(input logic [7:0] b);
      logic [7:0] s;
      int k;
      reg_wr(2'h1, b);
      s = 8'h01;
      k = 0;
      while (s[0] !== 1'b0 && k < 300) begin
         reg_rd(2'h2, s);
         k++;
      end
   endtask : send_byte
   // one selected frame: opcode, then an optional data byte, then deselect
   task frame(input logic [1:0] w, input logic [7:0] op, input logic has_d,
              input logic [7:0] d);
      int n0;
      n0 = op_cnt;
      reg_wr(2'h0, {5'h00, w, 1'b1});
      send_byte(op);
      if (has_d) send_byte(d);
      reg_wr(2'h0, 8'h00);
      repeat (12) @(posedge clk_i);
      check(8'(op_cnt - n0), 8'h01);
      check(opcode, op);
   endtask : frame
   // opcode in single mode, then one byte read back at width w
   task rd_frame(input logic [7:0] op, input logic [1:0] w, output logic [7:0] d);
      reg_wr(2'h0, 8'h01);
      send_byte(op);
      reg_wr(2'h0, {5'h01, w, 1'b1});
      send_byte(8'h00);
      reg_rd(2'h1, d);
      reg_wr(2'h0, 8'h00);
      repeat (12) @(posedge clk_i);
   endtask : rd_frame
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      reset_i = 1'b1;
      reset_pin_n = 1'b1;
      rd_data = 8'hA5;
      addr = 2'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      errors = 0;
      checked = 0;
      cycles = 0;
      op_cnt = 0;
      repeat (5) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      check(8'(link.cs_n), 8'h01);
      check({4'h0, link.dev_oe_n}, 8'h0F);
      check(status, sfqf_pkg::SFQF_STATUS_RESET);
      check(8'(four_wire), 8'h00);
      $display("test reset state done");
      frame(sfqf_pkg::SFQF_W1, sfqf_pkg::SFQF_OP_ENTER_4W, 1'b0, 8'h00);
      check(mon1, 8'h38);
      check(8'(four_wire), 8'h00);
      frame(sfqf_pkg::SFQF_W1, sfqf_pkg::SFQF_OP_WR_STATUS, 1'b1, 8'h80);
      check(mon1, 8'h80);
      check(wr_data, 8'h80);
      check(8'(status[sfqf_pkg::SFQF_ST_QE]), 8'h01);
      $display("test quad enable done");
      frame(sfqf_pkg::SFQF_W1, sfqf_pkg::SFQF_OP_ENTER_4W, 1'b0, 8'h00);
      check(8'(four_wire), 8'h01);
      frame(sfqf_pkg::SFQF_W4, sfqf_pkg::SFQF_OP_EXIT_4W, 1'b0, 8'h00);
      check(8'(four_wire), 8'h00);
      $display("test four-wire mode done");
      frame(sfqf_pkg::SFQF_W1, sfqf_pkg::SFQF_OP_ENTER_4W, 1'b0, 8'h00);
      frame(sfqf_pkg::SFQF_W4, sfqf_pkg::SFQF_OP_EN_RST, 1'b0, 8'h00);
      check(8'(busy), 8'h00);
      frame(sfqf_pkg::SFQF_W4, sfqf_pkg::SFQF_OP_RST, 1'b0, 8'h00);
      check(mon4, 8'h99);
      check(8'(busy), 8'h01);
      n = 0;
      while (busy === 1'b1 && n < 4000) begin
         @(posedge clk_i);
         n++;
      end
      // frame tail already used some of the wait, hence the lower margin
      check(8'(n > sfqf_pkg::SFQF_TRST_CYC - 200 && n <= sfqf_pkg::SFQF_TRST_CYC), 8'h01);
      check(8'(four_wire), 8'h00);
      $display("test software reset done");
      frame(sfqf_pkg::SFQF_W1, sfqf_pkg::SFQF_OP_WR_STATUS, 1'b1, 8'h80);
      for (int i = 0; i < 6; i++) begin
         frame(sfqf_pkg::SFQF_W1, codes[i], 1'b0, 8'h00);
      end
      $display("test read codes done");
      rd_frame(sfqf_pkg::SFQF_OP_RD_STATUS, sfqf_pkg::SFQF_W1, rv);
      check(rv, 8'h80);
      rd_frame(sfqf_pkg::SFQF_OP_DUAL_OUT, sfqf_pkg::SFQF_W2, rv);
      check(rv, 8'hA5);
      rd_frame(sfqf_pkg::SFQF_OP_QUAD_OUT, sfqf_pkg::SFQF_W4, rv);
      check(rv, 8'hA5);
      $display("test reads done");
      @(posedge clk_i);
      reset_pin_n <= 1'b0;
      repeat (sfqf_pkg::SFQF_TRESET_CYC + 50) @(posedge clk_i);
      reset_pin_n <= 1'b1;
      repeat (10) @(posedge clk_i);
      check(status, sfqf_pkg::SFQF_STATUS_RESET);
      check(8'(four_wire), 8'h00);
      $display("test reset pin done");
      reg_wr(2'h0, 8'h01);
      send_byte(sfqf_pkg::SFQF_OP_RD_STATUS);
      reg_wr(2'h0, 8'h11);
      repeat (8) @(posedge clk_i);
      check(8'(paused), 8'h01);
      check({4'h0, link.dev_oe_n}, 8'h0F);
      reg_wr(2'h0, 8'h01);
      repeat (8) @(posedge clk_i);
      check(8'(paused), 8'h00);
      reg_wr(2'h0, 8'h00);
      repeat (12) @(posedge clk_i);
      $display("test pause done");
      print_verdict();
   end
endmodule : sfqf_front_end_test

// [tb/sfqf_link_chk.sv]
// link checker: select, serial clock and lane enables of sfqf_if
// assumes instantiation beside the link in the bench top, clk_i domain only
`timescale 1ns/1ps
module sfqf_link_chk (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic [3:0] host_do,
   input wire logic [3:0] host_oe_n,
   input wire logic [3:0] dev_do,
   input wire logic [3:0] dev_oe_n
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // the device sees select through a synchroniser, so allow it a few cycles
   cs_float_a: assert property (
      cs_n && $past(cs_n) && $past(cs_n, 2) && $past(cs_n, 3) && $past(cs_n, 4)
      |-> dev_oe_n == 4'hF) else $error("device drives a lane while deselected");
   lane_owner_a: assert property (
      (host_oe_n | dev_oe_n) == 4'hF) else $error("both ends drive one lane");
   idle_fall_a: assert property (
      $fell(cs_n) |-> !sclk) else $error("clock not low as select falls");
   idle_rise_a: assert property (
      $rose(cs_n) |-> !sclk && $past(!sclk)) else $error("clock not low as select rises");
   sclk_select_a: assert property (
      sclk |-> !cs_n) else $error("clock high while deselected");
   dev_fall_edge_a: assert property (
      $changed(dev_do) && dev_oe_n != 4'hF |-> !sclk)
      else $error("device output changed with clock high");
   host_low_edge_a: assert property (
      $changed(host_do) && host_oe_n != 4'hF |-> !sclk)
      else $error("host data changed with clock high");
   sclk_high_a: assert property (
      $rose(sclk) |=> sclk [*7] ##1 !sclk) else $error("clock high phase not eight cycles");
endmodule : sfqf_link_chk
